// ### charge_transfer_touch_sequencer_tb_top.sv
// self-checking bench for the touch sequencer
`timescale 1ns/1ps
`default_nettype none
module charge_transfer_touch_sequencer_tb_top;
  import touch_seq_pkg::*;
  logic mclk, rst, unitEnable, startWrite, doneClear, errorClear;
  logic extTrig, discharge, pinOverride, busy, chPrev, swPrev;
  logic sequenceStartBit, sequenceDoneFlag, maxCycleErrorFlag;
  seq_cfg_s cfg;
  logic [NUM_PINS-1:0] channelSelect, sampleSelect, switchControl;
  logic [NUM_PINS-1:0] pinOut, pinOe, analogSwitch;
  logic [NUM_GROUPS-1:0] groupEnable, sampleAboveThreshold;
  count_t [NUM_GROUPS-1:0] groupCycleCount;
  count_t [5:0] target;
  int n_errors, n_checks, cyc, r14Bad;
  int chR[$], chF[$], swR[$], swF[$];

  touch_sequencer i_touch_sequencer (.mclk(mclk), .rst(rst), .cfg(cfg),
    .unitEnable(unitEnable), .startWrite(startWrite),
    .doneClear(doneClear), .errorClear(errorClear),
    .channelSelect(channelSelect), .sampleSelect(sampleSelect),
    .groupEnable(groupEnable), .switchControl(switchControl),
    .externalTriggerPin(extTrig),
    .sampleAboveThreshold(sampleAboveThreshold), .pinOut(pinOut),
    .pinOe(pinOe), .analogSwitch(analogSwitch), .pinOverride(pinOverride),
    .sequenceStartBit(sequenceStartBit),
    .sequenceDoneFlag(sequenceDoneFlag),
    .maxCycleErrorFlag(maxCycleErrorFlag), .busy(busy),
    .groupCycleCount(groupCycleCount));

  touch_pad_model i_touch_pad_model (.mclk(mclk), .discharge(discharge),
    .target(target), .pinOut(pinOut), .pinOe(pinOe),
    .analogSwitch(analogSwitch),
    .sampleAboveThreshold(sampleAboveThreshold));

  always #5 mclk = ~mclk;

  // edge log of group zero's charge drive and sample switch
  always @(negedge mclk) begin
    cyc++;
    if (((pinOe[0] & pinOut[0]) === 1'b1) != chPrev)
      if (chPrev) chF.push_back(cyc); else chR.push_back(cyc);
    chPrev = ((pinOe[0] & pinOut[0]) === 1'b1);
    if ((analogSwitch[1] === 1'b1) != swPrev)
      if (swPrev) swF.push_back(cyc); else swR.push_back(cyc);
    swPrev = (analogSwitch[1] === 1'b1);
    // transfer must close both switches with both pins floating
    if (busy === 1'b1 && swPrev && (analogSwitch[0] !== 1'b1 ||
        pinOe[1:0] !== 2'h0))
      r14Bad++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // empty the sample capacitors, then start by software or by pin edge
  task automatic fire(input logic sw);
    chR.delete(); chF.delete(); swR.delete(); swF.delete();
    discharge = 1'b1;
    tick(1);
    discharge = 1'b0;
    if (sw) begin
      startWrite = 1'b1;
      tick(1);
      startWrite = 1'b0;
    end else
      extTrig = ~extTrig;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin tick(1); n++; end
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin tick(1); n++; end
    tick(2);
    check(n < 20000, 1'b1);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #300us;
    n_errors++;
    $display("[ERR] t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    mclk = 0; rst = 1; unitEnable = 1; startWrite = 0; doneClear = 0;
    errorClear = 0; extTrig = 0; discharge = 0; chPrev = 0; swPrev = 0;
    cfg = '0;
    channelSelect = 24'h111111;
    sampleSelect = 24'h222222;
    groupEnable = 6'h3f;
    switchControl = 24'ha5c3e1;
    target = {14'h0002, 14'h0006, 14'h0001, 14'h0005, 14'h0003, 14'h0008};
    tick(12);
    rst = 0;
    tick(3);
    // idle after reset: pins, switches, override
    check(busy, 1'b0);
    check(sequenceDoneFlag | maxCycleErrorFlag, 1'b0);
    check(groupCycleCount[0], 14'h0000);
    check(pinOe, 24'hffffff);
    check(pinOut, 24'h000000);
    check(analogSwitch, 24'ha5c3e1);
    check(pinOverride, 1'b1);
    cfg.idlePinMode = 1'b1;
    unitEnable = 0;
    tick(2);
    check(pinOe, 24'h000000);
    check(pinOverride, 1'b0);
    unitEnable = 1;
    switchControl = 24'h000000;
    tick(2);
    check(analogSwitch, 24'h000000);
    $display("test idle done");

    // software run with spread-spectrum extension
    cfg.chargeDuration = 4'h1;
    cfg.transferDuration = 4'h2;
    cfg.transferClockDivider = 3'h1;
    cfg.extendChargeEnable = 1'b1;
    cfg.extendMaxDuration = 7'h02;
    cfg.extensionDivider = 1'b1;
    fire(1'b1);
    tick(10);
    startWrite = 1'b1; // ignored while running
    tick(1);
    startWrite = 1'b0;
    wait_done();
    check(chR.size(), 8);
    for (int i = 0; i < 8; i++) begin
      check(chF[i] - chR[i],
            4 + 2 * ((i % 6) <= 3 ? i % 6 : 6 - i % 6));
      check(swF[i] - swR[i], 6);
      check(swR[i] - chF[i], 2);
      if (i < 7) check(chR[i+1] - swF[i], 5);
    end
    for (int g = 0; g < 6; g++) check(groupCycleCount[g], target[g]);
    check({sequenceDoneFlag, maxCycleErrorFlag}, 2'h2);
    check(sequenceStartBit, 1'b0);
    check(r14Bad, 0);
    doneClear = 1'b1;
    tick(1);
    doneClear = 1'b0;
    tick(1);
    check(sequenceDoneFlag, 1'b0);
    $display("test software run done");

    // pin trigger on both edges, group zero disabled and never reached
    cfg.extendChargeEnable = 1'b0;
    cfg.triggerSourceSelect = 1'b1;
    groupEnable = 6'h3e;
    target = {14'h0002, 14'h0002, 14'h0002, 14'h0002, 14'h0002, 14'h3fff};
    for (int es = 0; es < 2; es++) begin
      cfg.triggerEdgeSelect = es[0];
      extTrig = ~es[0];
      tick(5);
      startWrite = 1'b1;
      tick(1);
      startWrite = 1'b0;
      tick(6);
      check(busy, 1'b0);
      check(sequenceStartBit, 1'b0);
      fire(1'b0);
      wait_done();
      check(chR.size(), 2);
      check(chF[1] - chR[1], 4);
      check(groupCycleCount[3], 14'h0002);
      check(sequenceDoneFlag, 1'b1);
      doneClear = 1'b1;
      tick(1);
      doneClear = 1'b0;
    end
    $display("test pin trigger done");

    // cycle limit reached with one group never at threshold
    cfg.triggerSourceSelect = 1'b0;
    cfg.chargeDuration = 4'h0;
    cfg.transferDuration = 4'h0;
    cfg.transferClockDivider = 3'h0;
    groupEnable = 6'h3f;
    fire(1'b1);
    wait_done();
    check(chR.size(), 255);
    check({sequenceDoneFlag, maxCycleErrorFlag}, 2'h1);
    check(groupCycleCount[2], 14'h0002);
    errorClear = 1'b1;
    tick(1);
    errorClear = 1'b0;
    tick(1);
    check(maxCycleErrorFlag, 1'b0);
    $display("test cycle limit done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ### tick_divider.sv
// power-of-two tick generator derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // control
  input  wire logic       restart,
  input  wire logic [2:0] divCode,
  // tick out
  output logic            tick
);
  logic [6:0] countFf;
  logic [6:0] mask;

  // divide by 2**divCode; mask selects the rollover point
  assign mask = 7'((8'h01 << divCode) - 8'h01);
  assign tick = (countFf & mask) == mask;

  // free counter, re-phased at each restart so durations are exact
  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      countFf <= 7'h00;
    end else begin
      countFf <= countFf + 7'h01;
    end
  end
endmodule
`default_nettype wire

// ### touch_pad_model.sv
// behavioural electrode and sample capacitor model for each group
`timescale 1ns/1ps
`default_nettype none
module touch_pad_model (
  // bench control
  input  wire logic                                 mclk,
  input  wire logic                                 discharge,
  input  wire touch_seq_pkg::count_t [5:0]          target,
  // pad side of the sequencer
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0]   pinOut,
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0]   pinOe,
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0]   analogSwitch,
  output logic [touch_seq_pkg::NUM_GROUPS-1:0]      sampleAboveThreshold
);
  import touch_seq_pkg::*;
  count_t [NUM_GROUPS-1:0] level;
  logic [NUM_GROUPS-1:0]   charged;
  logic [NUM_GROUPS-1:0]   swPrev;

  // charge only moves when the electrode was driven high beforehand
  always_ff @(posedge mclk) begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      swPrev[g] <= analogSwitch[4*g+1];
      if (discharge) begin
        level[g]   <= '0;
        charged[g] <= 1'b0;
      end else begin
        if (pinOe[4*g] && pinOut[4*g])
          charged[g] <= 1'b1;
        if (analogSwitch[4*g+1] && !swPrev[g] && charged[g]) begin
          level[g]   <= level[g] + 14'h0001;
          charged[g] <= 1'b0;
        end
      end
    end
  end

  // comparator without hysteresis, low until the count reaches target
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++)
      sampleAboveThreshold[g] = (level[g] >= target[g]);
  end
endmodule
`default_nettype wire

// ### touch_seq_pkg.sv
// shared constants, types and state codes for the touch sequencer
`default_nettype none
package touch_seq_pkg;
  localparam int NUM_GROUPS = 6;
  localparam int PINS_PER_GROUP = 4;
  localparam int NUM_PINS = NUM_GROUPS * PINS_PER_GROUP;
  localparam int CNT_W = 14;
  localparam logic [1:0] BUF_CYCLES = 2'h2;
  localparam logic [2:0] MAX_DIV_CODE = 3'h7;
  localparam logic [2:0] MCN_RESERVED = 3'h7;
  localparam logic [CNT_W-1:0] LIMIT_255 = 14'h00ff;

  // pin modes driven toward the pad
  typedef enum logic [1:0] {
    PIN_FLOAT = 2'h0,
    PIN_HIGH  = 2'h1,
    PIN_LOW   = 2'h2
  } pin_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_BUF1     = 4'h1,
    ST_CHARGE   = 4'h2,
    ST_EXTEND   = 4'h3,
    ST_BUF2     = 4'h4,
    ST_TRANSFER = 4'h5,
    ST_BUF3     = 4'h6,
    ST_COMPARE  = 4'h7
  } seq_state_e;

  // static configuration of one measurement
  typedef struct packed {
    logic [3:0] chargeDuration;
    logic [3:0] transferDuration;
    logic [6:0] extendMaxDuration;
    logic       extendChargeEnable;
    logic       extensionDivider;
    logic [2:0] transferClockDivider;
    logic [2:0] maxCycleLimit;
    logic       idlePinMode;
    logic       triggerEdgeSelect;
    logic       triggerSourceSelect;
  } seq_cfg_s;

  typedef logic [CNT_W-1:0] count_t;
endpackage
`default_nettype wire

// ### touch_sequencer.sv
// charge-transfer touch sequencer: fsm, group counters, pin and switch control
//
// Functional notes
// R1: after reset sit idle until a start condition.
// R2: software trigger mode starts on start bit written one.
// R3: hardware mode starts on selected edge of the trigger pin.
// R4: each state advances only when its duration is reached.
// R5: extend-charge state occurs only when extension is enabled.
// R6: compare ends when all enabled groups reach threshold, else loop.
// R7: stop after compare of the cycle that hits the maximum.
// R8: each group keeps its own readable cycle counter.
// R9: each buffer state lasts exactly two system clocks.
// R10: charge and transfer last their duration fields in transfer ticks.
// R11: transfer and extension ticks come from separate independent dividers.
// R12: control and fsm are clocked by the system clock.
// R13: extension length follows a triangle zero up to peak and back.
// R14: transfer closes both switches with pins floating.
// R15: third buffer and compare open switches, pins floating.
// R16: idle pins take the idle pin-mode selection.
// R17: idle switches follow the software switch-control bits.
// R18: idle switch control applies even to unassigned pins.
// R19: enabled unit overrides other pin control.
// R20: done flag sets on threshold stop, clears by write-one.
// R21: max-cycle error flag sets on limit stop, clears by write-one.
// R22: software uses one sample pin per group, never shared.
// R23: software configures, enables, triggers, waits, clears, reads.
// R24: software may clear hysteresis bits for noise immunity.
// R25: idle pin mode zero drives low, one leaves floating.
// R26: max-cycle codes map to 255 through 16383.
// R27: transfer divider divides by one up to 128.
// R28: duration field n lasts n plus one ticks.
// R29: group counters clear at start and freeze at threshold.
// R30: start bit self-clears at idle; starts while running ignored.
`timescale 1ns/1ps
`default_nettype none
module touch_sequencer (
  // clock and reset
  input  wire logic                               mclk,
  input  wire logic                               rst,
  // configuration and control
  input  wire touch_seq_pkg::seq_cfg_s            cfg,
  input  wire logic                               unitEnable,
  input  wire logic                               startWrite,
  input  wire logic                               doneClear,
  input  wire logic                               errorClear,
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0] channelSelect,
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0] sampleSelect,
  input  wire logic [touch_seq_pkg::NUM_GROUPS-1:0] groupEnable,
  input  wire logic [touch_seq_pkg::NUM_PINS-1:0] switchControl,
  // pads
  input  wire logic                               externalTriggerPin,
  input  wire logic [touch_seq_pkg::NUM_GROUPS-1:0] sampleAboveThreshold,
  output logic [touch_seq_pkg::NUM_PINS-1:0]      pinOut,
  output logic [touch_seq_pkg::NUM_PINS-1:0]      pinOe,
  output logic [touch_seq_pkg::NUM_PINS-1:0]      analogSwitch,
  output logic                                    pinOverride,
  // status
  output logic                                    sequenceStartBit,
  output logic                                    sequenceDoneFlag,
  output logic                                    maxCycleErrorFlag,
  output logic                                    busy,
  output touch_seq_pkg::count_t [touch_seq_pkg::NUM_GROUPS-1:0] groupCycleCount
);
  import touch_seq_pkg::*;

  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [1:0] trigSync_ff;
  logic       trigPrev_ff;
  logic [NUM_GROUPS-1:0] thrSync1_ff;
  logic [NUM_GROUPS-1:0] thrSync2_ff;
  logic       startBit_ff;
  logic       doneFlag_ff;
  logic       errFlag_ff;
  logic [4:0] durCount_ff;
  logic [7:0] extCount_ff;
  logic [7:0] extTarget_ff;
  logic       extFalling_ff;
  count_t     cycle_ff;
  count_t     cycleLimit;
  count_t     grpCount_ff [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] grpDone_ff;
  logic [NUM_PINS-1:0]   pinOut_ff;
  logic [NUM_PINS-1:0]   pinOe_ff;
  logic [NUM_PINS-1:0]   asw_ff;
  logic       ctTick;
  logic       ecTick;
  logic       trigEdge;
  logic       startReq;
  logic       stateDone;
  logic       allReached;
  logic       limitHit;
  logic       stateEntry;

  // pin inputs pass two flops before any logic sees them
  always_ff @(posedge mclk) begin
    if (rst) begin
      thrSync1_ff <= '0;
      thrSync2_ff <= '0;
    end else begin
      thrSync1_ff <= sampleAboveThreshold;
      thrSync2_ff <= thrSync1_ff;
    end
  end

  // trigger sync runs through reset: settles to the pin, no false edge
  always_ff @(posedge mclk) begin
    trigSync_ff <= {trigSync_ff[0], externalTriggerPin};
    trigPrev_ff <= trigSync_ff[1];
  end

  // edge select: 0 falling, 1 rising
  assign trigEdge = cfg.triggerEdgeSelect ?
                    (trigSync_ff[1] && !trigPrev_ff) :
                    (!trigSync_ff[1] && trigPrev_ff);
  assign startReq = unitEnable && (state_ff == ST_IDLE) &&
                    (cfg.triggerSourceSelect ? trigEdge       // R3
                                             : startBit_ff);  // R2

  // start bit: set by software, dropped when the sequence ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      startBit_ff <= 1'b0;
    end else if (startWrite && !cfg.triggerSourceSelect &&
                 state_ff == ST_IDLE) begin
      startBit_ff <= 1'b1;
    end else if (nxt_state == ST_IDLE && state_ff != ST_IDLE) begin
      startBit_ff <= 1'b0; // R30
    end
  end

  // restart dividers on each state entry so durations never come short
  assign stateEntry = nxt_state != state_ff;

  // two independent dividers off the system clock
  tick_divider uCtDiv (                                    // R11
    .mclk    (mclk),
    .rst     (rst),
    .restart (stateEntry),
    .divCode (cfg.transferClockDivider),                   // R27
    .tick    (ctTick)
  );
  tick_divider uEcDiv (                                    // R11
    .mclk    (mclk),
    .rst     (rst),
    .restart (stateEntry),
    .divCode ({2'h0, cfg.extensionDivider}),
    .tick    (ecTick)
  );

  // max cycle code to limit, reserved code treated as the smallest
  always_comb begin
    if (cfg.maxCycleLimit == MCN_RESERVED) begin
      cycleLimit = LIMIT_255;
    end else begin
      cycleLimit = count_t'(({1'b0, LIMIT_255} << cfg.maxCycleLimit)
                            | 15'h00ff);                   // R26
    end
  end

  assign allReached = ((thrSync2_ff | ~groupEnable) == '1);
  assign limitHit   = cycle_ff >= cycleLimit;

  // per-state duration counter; buffers count clocks, others ticks
  always_comb begin
    case (state_ff)
      ST_BUF1, ST_BUF2, ST_BUF3:
        stateDone = durCount_ff == 5'(BUF_CYCLES - 2'h1);  // R9
      ST_CHARGE:
        stateDone = ctTick &&
                    durCount_ff == {1'b0, cfg.chargeDuration};   // R28
      ST_TRANSFER:
        stateDone = ctTick &&
                    durCount_ff == {1'b0, cfg.transferDuration}; // R10
      ST_EXTEND:
        stateDone = ecTick &&
                    extCount_ff == extTarget_ff - 8'h01;   // R13
      ST_COMPARE:
        stateDone = 1'b1;
      default:
        stateDone = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (startReq) begin
          nxt_state = ST_BUF1;
        end
      ST_BUF1:
        if (stateDone) begin
          nxt_state = ST_CHARGE;
        end
      ST_CHARGE:
        if (stateDone) begin
          // zero-length extension is skipped: a state lasts a clock at least
          nxt_state = (cfg.extendChargeEnable && extTarget_ff != 8'h00) ?
                      ST_EXTEND : ST_BUF2; // R5
        end
      ST_EXTEND:
        if (stateDone) begin
          nxt_state = ST_BUF2;
        end
      ST_BUF2:
        if (stateDone) begin
          nxt_state = ST_TRANSFER;
        end
      ST_TRANSFER:
        if (stateDone) begin
          nxt_state = ST_BUF3;
        end
      ST_BUF3:
        if (stateDone) begin
          nxt_state = ST_COMPARE;
        end
      ST_COMPARE:
        nxt_state = (allReached || limitHit) ? ST_IDLE : ST_BUF1; // R6 R7
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!unitEnable) begin
      nxt_state = ST_IDLE;
    end
  end

  // fsm register, system clock only
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= ST_IDLE; // R1
    end else begin
      state_ff <= nxt_state; // R4 R12
    end
  end

  // duration counters restart on every state change
  always_ff @(posedge mclk) begin
    if (rst || stateEntry) begin
      durCount_ff <= 5'h00;
      extCount_ff <= 8'h00;
    end else begin
      if (state_ff == ST_BUF1 || state_ff == ST_BUF2 ||
          state_ff == ST_BUF3 || ctTick) begin
        durCount_ff <= durCount_ff + 5'h01;
      end
      if (ecTick && state_ff == ST_EXTEND) begin
        extCount_ff <= extCount_ff + 8'h01;
      end
    end
  end

  // spread spectrum triangle: 0 up to peak extend_max_duration+1, then back to 0
  always_ff @(posedge mclk) begin
    if (rst || startReq) begin
      extTarget_ff  <= 8'h00;
      extFalling_ff <= 1'b0;
    end else if (state_ff == ST_COMPARE && nxt_state == ST_BUF1) begin
      if (!extFalling_ff) begin
        if (extTarget_ff == {1'b0, cfg.extendMaxDuration} + 8'h01) begin
          extTarget_ff  <= extTarget_ff - 8'h01;
          extFalling_ff <= 1'b1;
        end else begin
          extTarget_ff <= extTarget_ff + 8'h01; // R13
        end
      end else if (extTarget_ff == 8'h00) begin
        extTarget_ff  <= 8'h01;
        extFalling_ff <= 1'b0;
      end else begin
        extTarget_ff <= extTarget_ff - 8'h01; // R13
      end
    end
  end

  // cycle number, counted as each cycle leaves the first buffer state
  always_ff @(posedge mclk) begin
    if (rst || startReq) begin
      cycle_ff <= '0;
    end else if (state_ff == ST_BUF1 && stateEntry) begin
      cycle_ff <= cycle_ff + count_t'(1);
    end
  end

  // per-group counters; freeze once the group reaches threshold
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gGroup
    always_ff @(posedge mclk) begin
      if (rst || startReq) begin
        grpCount_ff[g] <= '0; // R29
        grpDone_ff[g]  <= 1'b0;
      end else if (state_ff == ST_COMPARE && !grpDone_ff[g]) begin
        grpCount_ff[g] <= grpCount_ff[g] + count_t'(1); // R8
        grpDone_ff[g]  <= thrSync2_ff[g]; // R29
      end
    end
    assign groupCycleCount[g] = grpCount_ff[g];
  end

  // stop flags; a new set wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      doneFlag_ff <= 1'b0;
      errFlag_ff  <= 1'b0;
    end else begin
      if (state_ff == ST_COMPARE && allReached) begin
        doneFlag_ff <= 1'b1; // R20
      end else if (doneClear) begin
        doneFlag_ff <= 1'b0; // R20
      end
      if (state_ff == ST_COMPARE && !allReached && limitHit) begin
        errFlag_ff <= 1'b1; // R21
      end else if (errorClear) begin
        errFlag_ff <= 1'b0; // R21
      end
    end
  end

  // pad and switch control per pin, from the next state
  for (genvar p = 0; p < NUM_PINS; p++) begin : gPin
    always_ff @(posedge mclk) begin
      if (rst) begin
        pinOut_ff[p] <= 1'b0;
        pinOe_ff[p]  <= 1'b0;
        asw_ff[p]    <= 1'b0;
      end else if (nxt_state == ST_IDLE) begin
        pinOut_ff[p] <= 1'b0;
        pinOe_ff[p]  <= !cfg.idlePinMode; // R16 R25
        asw_ff[p]    <= switchControl[p]; // R17 R18
      end else begin
        pinOut_ff[p] <= 1'b1;
        pinOe_ff[p]  <= channelSelect[p] &&
                        (nxt_state == ST_CHARGE || nxt_state == ST_EXTEND);
        asw_ff[p]    <= (channelSelect[p] || sampleSelect[p]) &&
                        nxt_state == ST_TRANSFER; // R14 R15
      end
    end
  end

  assign pinOut            = pinOut_ff;
  assign pinOe             = pinOe_ff;
  assign analogSwitch      = asw_ff;
  assign pinOverride       = unitEnable; // R19
  assign sequenceStartBit  = startBit_ff;
  assign sequenceDoneFlag  = doneFlag_ff;
  assign maxCycleErrorFlag = errFlag_ff;
  assign busy              = state_ff != ST_IDLE;

  // checks
  chk_reset_idle: assert property (@(posedge mclk)
    $past(rst) |-> state_ff == ST_IDLE) // R1
    else $error("not idle after reset");
  chk_soft_start: assert property (@(posedge mclk) disable iff (rst)
    state_ff == ST_IDLE && unitEnable && !cfg.triggerSourceSelect &&
    startBit_ff |=> state_ff == ST_BUF1) // R2
    else $error("software start missed");
  chk_buf_length: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_ff == ST_BUF2) && unitEnable |=>
    state_ff == ST_BUF2 ##1 state_ff != ST_BUF2) // R9
    else $error("buffer state not two clocks");
  chk_extend_skip: assert property (@(posedge mclk) disable iff (rst)
    !cfg.extendChargeEnable |-> state_ff != ST_EXTEND ||
    $past(state_ff) == ST_EXTEND) // R5
    else $error("extend entered while disabled");
  chk_transfer_sw: assert property (@(posedge mclk) disable iff (rst)
    state_ff == ST_TRANSFER && $past(state_ff) == ST_TRANSFER |->
    analogSwitch == (channelSelect | sampleSelect)) // R14
    else $error("switches not closed in transfer");
  chk_compare_sw: assert property (@(posedge mclk) disable iff (rst)
    state_ff == ST_COMPARE |-> analogSwitch == '0 && pinOe == '0) // R15
    else $error("switches closed in compare");
  chk_done_flag: assert property (@(posedge mclk) disable iff (rst)
    state_ff == ST_COMPARE && allReached |=> sequenceDoneFlag &&
    state_ff == ST_IDLE) // R20 R6
    else $error("done flag not set");
  chk_limit_stop: assert property (@(posedge mclk) disable iff (rst)
    state_ff == ST_COMPARE && limitHit && !allReached |=>
    maxCycleErrorFlag && state_ff == ST_IDLE) // R21 R7
    else $error("limit stop missed");
  chk_start_ignored: assert property (@(posedge mclk) disable iff (rst)
    busy && (nxt_state == ST_IDLE || !sequenceStartBit) |=>
    !sequenceStartBit) // R30
    else $error("start bit set while running or kept at end");

  cov_done: cover property (@(posedge mclk) sequenceDoneFlag);
  cov_limit: cover property (@(posedge mclk) maxCycleErrorFlag);
  cov_extend: cover property (@(posedge mclk) state_ff == ST_EXTEND);
endmodule
`default_nettype wire
